// *** prag_bus_if.sv ***
// Internal register write/read carrier between the bus slave and the register file.
`timescale 1ns/1ps
interface prag_bus_if;
  logic       wr_en;
  logic [7:0] adr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hit;
  modport slave  (output wr_en, output adr, output wdata, input rdata, input hit);
  modport regs   (input wr_en, input adr, input wdata, output rdata, output hit);
endinterface

// *** prag_gate_gen.sv ***
// Gate pulse generator counting clock cycles from the horizontal sync reference.
`timescale 1ns/1ps
module prag_gate_gen #(
  parameter int DELAY_W = 10
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               hsync_ref_i,
  input  wire logic [DELAY_W-1:0] start_i,
  input  wire logic [DELAY_W-1:0] end_i,
  output logic                    gate_o
);
  logic [DELAY_W-1:0] count;
  logic               counting;

  // Count stops at its ceiling so a missing sync never wraps and re-opens the gate.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count    <= '0;
      counting <= 1'b0;
    end else if (hsync_ref_i) begin
      count    <= '0;
      counting <= 1'b1;
    end else if (counting && (count != {DELAY_W{1'b1}})) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_o <= 1'b0;
    end else begin
      gate_o <= counting && !hsync_ref_i && (count >= start_i) && (count < end_i);
    end
  end

  property p_gate_window;
    @(posedge clk_i) disable iff (rst_i)
      gate_o |-> ($past(count) >= $past(start_i)) && ($past(count) < $past(end_i));
  endproperty
  a_gate_window: assert property (p_gate_window) else $error("gate outside window");

  property p_gate_sync_clear;
    @(posedge clk_i) disable iff (rst_i)
      hsync_ref_i |=> !gate_o;
  endproperty
  a_gate_sync_clear: assert property (p_gate_sync_clear) else $error("gate high after sync");
endmodule

// *** prag_pkg.sv ***
// Constants shared by the chroma ratio and AGC gate register slice.
package prag_pkg;
  // ---------------------------------------------------------------------------
  // Register sub-addresses.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RATIO_LOW_ADR  = 8'h06;
  localparam logic [7:0] RATIO_HIGH_ADR = 8'h07;
  localparam logic [7:0] START_LOW_ADR  = 8'h08;
  localparam logic [7:0] START_HIGH_ADR = 8'h09;
  localparam logic [7:0] END_LOW_ADR    = 8'h0a;
  localparam logic [7:0] END_HIGH_ADR   = 8'h0b;
  // ---------------------------------------------------------------------------
  // Reset values and field layout.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RATIO_LOW_RST  = 8'hc1;
  localparam logic [7:0] RATIO_HIGH_RST = 8'h87;
  localparam logic [7:0] START_LOW_RST  = 8'h3f;
  localparam logic [1:0] START_HIGH_RST = 2'h3;
  localparam logic [7:0] END_LOW_RST    = 8'h00;
  localparam logic [1:0] END_HIGH_RST   = 2'h0;
  localparam int         DELAY_W        = 10;
  localparam int         HIGH_W         = 2;
  localparam int         RATIO_W        = 16;
  localparam logic [5:0] HIGH_PAD       = 6'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// *** prag_top.sv ***
// Top of the chroma ratio and AGC gate register slice with its Wishbone port.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module prag_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        hsync_ref_i,
  output logic      [15:0] chroma_ratio_o,
  output logic             agc_gate_pulse_o
);
  // ---------------------------------------------------------------------------
  // Register storage.
  // ---------------------------------------------------------------------------
  logic [7:0] chroma_ratio_low;
  logic [7:0] chroma_ratio_high;
  logic [7:0] agc_gate_start_low;
  logic [1:0] agc_gate_start_high;
  logic [7:0] agc_gate_end_low;
  logic [1:0] agc_gate_end_high;
  logic       hsync_meta;
  logic       hsync_sync;
  logic       hsync_prev;
  logic       hsync_rise;

  prag_bus_if bus ();

  prag_wb_slave u_slave (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (wb_cyc_i),
    .stb_i (wb_stb_i),
    .we_i  (wb_we_i),
    .adr_i (wb_adr_i),
    .sel_i (wb_sel_i),
    .dat_i (wb_dat_i),
    .dat_o (wb_dat_o),
    .ack_o (wb_ack_o),
    .bus   (bus)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chroma_ratio_low  <= prag_pkg::RATIO_LOW_RST;
      chroma_ratio_high <= prag_pkg::RATIO_HIGH_RST;
    end else if (bus.wr_en) begin
      if (bus.adr == prag_pkg::RATIO_LOW_ADR) begin
        chroma_ratio_low <= bus.wdata;
      end
      if (bus.adr == prag_pkg::RATIO_HIGH_ADR) begin
        chroma_ratio_high <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      agc_gate_start_low  <= prag_pkg::START_LOW_RST;
      agc_gate_start_high <= prag_pkg::START_HIGH_RST;
    end else if (bus.wr_en) begin
      if (bus.adr == prag_pkg::START_LOW_ADR) begin
        agc_gate_start_low <= bus.wdata;
      end
      if (bus.adr == prag_pkg::START_HIGH_ADR) begin
        agc_gate_start_high <= bus.wdata[prag_pkg::HIGH_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      agc_gate_end_low  <= prag_pkg::END_LOW_RST;
      agc_gate_end_high <= prag_pkg::END_HIGH_RST;
    end else if (bus.wr_en) begin
      if (bus.adr == prag_pkg::END_LOW_ADR) begin
        agc_gate_end_low <= bus.wdata;
      end
      if (bus.adr == prag_pkg::END_HIGH_ADR) begin
        agc_gate_end_high <= bus.wdata[prag_pkg::HIGH_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux.
  // ---------------------------------------------------------------------------
  always_comb begin
    bus.hit   = 1'b1;
    bus.rdata = 8'h00;
    unique case (bus.adr)
      prag_pkg::RATIO_LOW_ADR:  bus.rdata = chroma_ratio_low;
      prag_pkg::RATIO_HIGH_ADR: bus.rdata = chroma_ratio_high;
      prag_pkg::START_LOW_ADR:  bus.rdata = agc_gate_start_low;
      prag_pkg::START_HIGH_ADR: bus.rdata = {prag_pkg::HIGH_PAD, agc_gate_start_high};
      prag_pkg::END_LOW_ADR:    bus.rdata = agc_gate_end_low;
      prag_pkg::END_HIGH_ADR:   bus.rdata = {prag_pkg::HIGH_PAD, agc_gate_end_high};
      default:                  bus.hit   = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sync reference from the pin.
  // ---------------------------------------------------------------------------
  // The sync comes from outside the clock domain, so it passes two flops first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hsync_meta <= 1'b0;
      hsync_sync <= 1'b0;
      hsync_prev <= 1'b0;
    end else begin
      hsync_meta <= hsync_ref_i;
      hsync_sync <= hsync_meta;
      hsync_prev <= hsync_sync;
    end
  end
  assign hsync_rise = hsync_sync && !hsync_prev;

  prag_gate_gen #(
    .DELAY_W (prag_pkg::DELAY_W)
  ) u_gate (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .hsync_ref_i (hsync_rise),
    .start_i     ({agc_gate_start_high, agc_gate_start_low}),
    .end_i       ({agc_gate_end_high, agc_gate_end_low}),
    .gate_o      (agc_gate_pulse_o)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chroma_ratio_o <= {prag_pkg::RATIO_HIGH_RST, prag_pkg::RATIO_LOW_RST};
    end else begin
      chroma_ratio_o <= {chroma_ratio_high, chroma_ratio_low};
    end
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  sequence s_ratio_write(logic [7:0] a);
    bus.wr_en && (bus.adr == a);
  endsequence

  property p_ratio_low_write;
    @(posedge clk_i) disable iff (rst_i)
      s_ratio_write(prag_pkg::RATIO_LOW_ADR) |=> ##1 (chroma_ratio_o[7:0] == $past(bus.wdata, 2));
  endproperty
  a_ratio_low_write: assert property (p_ratio_low_write) else $error("low byte not applied");

  property p_ratio_high_write;
    @(posedge clk_i) disable iff (rst_i)
      s_ratio_write(prag_pkg::RATIO_HIGH_ADR) |=> ##1 (chroma_ratio_o[15:8] == $past(bus.wdata, 2));
  endproperty
  a_ratio_high_write: assert property (p_ratio_high_write) else $error("high byte not applied");

  property p_ratio_follows;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (chroma_ratio_o == $past({chroma_ratio_high, chroma_ratio_low}));
  endproperty
  a_ratio_follows: assert property (p_ratio_follows) else $error("ratio output stale");

  property p_ratio_reset;
    @(posedge clk_i) $fell(rst_i) |->
      (chroma_ratio_o == {prag_pkg::RATIO_HIGH_RST, prag_pkg::RATIO_LOW_RST})
      && (chroma_ratio_low == prag_pkg::RATIO_LOW_RST);
  endproperty
  a_ratio_reset: assert property (p_ratio_reset) else $error("ratio reset wrong");

  property p_start_reset;
    @(posedge clk_i) $fell(rst_i) |->
      {agc_gate_start_high, agc_gate_start_low} == {prag_pkg::START_HIGH_RST, prag_pkg::START_LOW_RST};
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("start reset wrong");

  property p_end_reset;
    @(posedge clk_i) $fell(rst_i) |->
      {agc_gate_end_high, agc_gate_end_low} == {prag_pkg::END_HIGH_RST, prag_pkg::END_LOW_RST};
  endproperty
  a_end_reset: assert property (p_end_reset) else $error("end reset wrong");

  property p_high_pad_zero;
    @(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i[9:2]) == prag_pkg::START_HIGH_ADR
        || $past(wb_adr_i[9:2]) == prag_pkg::END_HIGH_ADR)) |-> (wb_dat_o[7:2] == prag_pkg::HIGH_PAD);
  endproperty
  a_high_pad_zero: assert property (p_high_pad_zero) else $error("pad bits nonzero");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_start_low_write;
    @(posedge clk_i) disable iff (rst_i)
      s_ratio_write(prag_pkg::START_LOW_ADR) |=> (agc_gate_start_low == $past(bus.wdata));
  endproperty
  a_start_low_write: assert property (p_start_low_write) else $error("start low not applied");

  property p_end_low_write;
    @(posedge clk_i) disable iff (rst_i)
      s_ratio_write(prag_pkg::END_LOW_ADR) |=> (agc_gate_end_low == $past(bus.wdata));
  endproperty
  a_end_low_write: assert property (p_end_low_write) else $error("end low not applied");

  // Only the two delay bits may follow a high-byte write; the rest of the byte is dropped.
  property p_start_high_masked;
    @(posedge clk_i) disable iff (rst_i)
      s_ratio_write(prag_pkg::START_HIGH_ADR)
        |=> (agc_gate_start_high == $past(bus.wdata[prag_pkg::HIGH_W-1:0]));
  endproperty
  a_start_high_masked: assert property (p_start_high_masked) else $error("start high wrong");

  property p_end_high_masked;
    @(posedge clk_i) disable iff (rst_i)
      s_ratio_write(prag_pkg::END_HIGH_ADR)
        |=> (agc_gate_end_high == $past(bus.wdata[prag_pkg::HIGH_W-1:0]));
  endproperty
  a_end_high_masked: assert property (p_end_high_masked) else $error("end high wrong");

  property p_unmapped_keeps_ratio;
    @(posedge clk_i) disable iff (rst_i)
      (bus.wr_en && !bus.hit) |=> $stable(chroma_ratio_low) && $stable(chroma_ratio_high);
  endproperty
  a_unmapped_keeps_ratio: assert property (p_unmapped_keeps_ratio) else $error("ratio hit");
endmodule

// *** prag_wb_slave.sv ***
// Classic Wishbone slave that turns one bus cycle into one register access.
`timescale 1ns/1ps
module prag_wb_slave (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  prag_bus_if.slave        bus
);
  logic req;

  // The ack is registered, so every access answers exactly one cycle after it is seen.
  assign req       = cyc_i && stb_i && !ack_o;
  assign bus.adr   = adr_i[9:2];
  assign bus.wdata = dat_i[7:0];
  assign bus.wr_en = req && we_i && sel_i[0] && (adr_i[31:10] == 22'h000000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= prag_pkg::UNMAPPED_DATA;
    end else if (req && !we_i) begin
      dat_o <= (bus.hit && (adr_i[31:10] == 22'h000000)) ? {24'h000000, bus.rdata}
                                                        : prag_pkg::UNMAPPED_DATA;
    end
  end
endmodule

// *** test_pll_ratio_agc_timing_regs.sv ***
// Self-checking testbench for the chroma ratio and AGC gate register slice.
`timescale 1ns/1ps
module test_pll_ratio_agc_timing_regs;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [31:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        hsync_ref;
  logic [15:0] chroma_ratio;
  logic        agc_gate_pulse;
  int          num_errors;
  int          n_tests;
  int          cycles;
  logic [31:0] rd;

  prag_top DUT (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .wb_cyc_i         (wb_cyc),
    .wb_stb_i         (wb_stb),
    .wb_we_i          (wb_we),
    .wb_adr_i         (wb_adr),
    .wb_sel_i         (wb_sel),
    .wb_dat_i         (wb_dat_w),
    .wb_dat_o         (wb_dat_r),
    .wb_ack_o         (wb_ack),
    .hsync_ref_i      (hsync_ref),
    .chroma_ratio_o   (chroma_ratio),
    .agc_gate_pulse_o (agc_gate_pulse)
  );

  // ---------------------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ---------------------------------------------------------------------------
  always #5 clk_i = ~clk_i;

  // The whole run needs under two thousand cycles, so this only trips on a hang.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Read data is taken at the very edge where ack is sampled high.
  // Only the bench timeout ends a wait for ack.
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
                         input logic [3:0] sel, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= {22'h000000, idx, 2'h0};
    wb_sel   <= sel;
    wb_dat_w <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d, 4'h1, rd);
  endtask

  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00, 4'hf, rd);
    check(rd, {24'h000000, exp});
  endtask

  // Pulses the line reference and counts gate cycles before and after loop cycle 250.
  task automatic line_check(input int exp_early, input int exp_late);
    int early;
    int late;
    early = 0;
    late = 0;
    @(posedge clk_i);
    hsync_ref <= 1'b1;
    for (int i = 0; i < 350; i++) begin
      @(posedge clk_i);
      if (i == 4) begin
        hsync_ref <= 1'b0;
      end
      @(negedge clk_i);
      if (agc_gate_pulse === 1'b1 && i < 250) early++;
      if (agc_gate_pulse === 1'b1 && i >= 250) late++;
    end
    check(early, exp_early);
    check(late, exp_late);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] exp [6] = '{8'hc1, 8'h87, 8'h3f, 8'h03, 8'h00, 8'h00};
    check(chroma_ratio, 32'h87c1);
    for (int i = 0; i < 6; i++) begin
      rd_check(8'(i + 6), exp[i]);
    end
  endtask

  task automatic t_gate_default();
    // Start 0x33f lies after end 0, so no pulse may appear.
    line_check(0, 0);
  endtask

  task automatic t_ratio();
    // 4 x 4.43361875 MHz over 27 MHz, times 65536, rounds to 0xa826.
    wr(prag_pkg::RATIO_LOW_ADR, 8'h26);
    wr(prag_pkg::RATIO_HIGH_ADR, 8'ha8);
    @(negedge clk_i);
    check(chroma_ratio, 32'ha826);
    rd_check(prag_pkg::RATIO_LOW_ADR, 8'h26);
    rd_check(prag_pkg::RATIO_HIGH_ADR, 8'ha8);
  endtask

  task automatic t_pads();
    wr(prag_pkg::START_HIGH_ADR, 8'hfe);
    rd_check(prag_pkg::START_HIGH_ADR, 8'h02);
    wb_xfer(1'b1, prag_pkg::END_HIGH_ADR, 8'hff, 4'h0, rd);
    rd_check(prag_pkg::END_HIGH_ADR, 8'h00);
    wr(prag_pkg::END_HIGH_ADR, 8'hfd);
    rd_check(prag_pkg::END_HIGH_ADR, 8'h01);
  endtask

  task automatic t_unmapped();
    wr(8'h0c, 8'h55);
    rd_check(8'h0c, 8'h00);
    rd_check(8'h05, 8'h00);
  endtask

  task automatic t_gate_prog();
    // Start 0x102 and end 0x106 need both high bytes and give four cycles.
    wr(prag_pkg::START_LOW_ADR, 8'h02);
    wr(prag_pkg::END_LOW_ADR, 8'h06);
    rd_check(prag_pkg::START_LOW_ADR, 8'h02);
    rd_check(prag_pkg::END_LOW_ADR, 8'h06);
    wr(prag_pkg::START_HIGH_ADR, 8'h01);
    line_check(0, 4);
  endtask

  // A reset in mid-run must bring every written byte back to its reset value.
  task automatic t_reset_again();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    t_reset();
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 32'h00000000;
    wb_sel = 4'h0;
    wb_dat_w = 32'h00000000;
    hsync_ref = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    t_reset();
    t_gate_default();
    t_ratio();
    t_pads();
    t_unmapped();
    t_gate_prog();
    t_reset_again();
    complete_run();
  end
endmodule
